// *** design/src_error_and_interrupt_status.sv ***
// converter error, converter mask and interrupt status registers
// assumes register strobes and event inputs are on i_clk already
//
// Notes on behaviour
// - converter error register is read only; writes leave its flags alone
// - too-slow flag, bit 3, sets when converter clock is too slow
// - left-clip flag, bit 2, sets on clipping, holds until read clears it
// - right-clip flag, bit 1, sets on clipping, holds until read clears it
// - mask bit 2 lets left-clip flag raise the interrupt when one
// - mask bit 1 lets right-clip flag raise the interrupt when one
// - mask bit 0 lets the muted indication raise the interrupt when one
// - status bit 3 sets on status A/B differ, held, never interrupts
// - status bit 2 sets on new user block, held until status read
module src_error_and_interrupt_status (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [src_status_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [src_status_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [src_status_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_too_slow,
  input wire logic i_left_clip,
  input wire logic i_right_clip,
  input wire logic i_converter_output_muted,
  input wire logic i_tx_status_buffer_loaded,
  input wire logic i_tx_user_buffer_empty,
  input wire logic i_tx_status_block_sent,
  input wire logic i_rx_status_a_b_differ,
  input wire logic i_rx_user_block_new,
  input wire logic i_rx_status_block_event,
  input wire logic i_rx_error_summary,
  input wire logic [src_status_pkg::DATA_W-1:0] i_interrupt_enables,
  output logic o_irq
);
  import src_status_pkg::*;

  // ***********************************************
  // address decode
  // ***********************************************
  wire sel_conv = (i_reg_addr == ADDR_CONV_ERR);
  wire sel_mask = (i_reg_addr == ADDR_CONV_MASK);
  wire sel_int = (i_reg_addr == ADDR_INT_STATUS);
  wire rd_conv = i_reg_rd && sel_conv;
  wire rd_int = i_reg_rd && sel_int;
  // writes to the error register decode to nothing
  wire wr_mask = i_reg_wr && sel_mask;

  // ***********************************************
  // converter error register
  // ***********************************************
  logic [CE_STICKY_W-1:0] conv_sticky;
  logic [DATA_W-1:0] conv_mask;
  logic [DATA_W-1:0] int_flags;

  wire [CE_STICKY_W-1:0] conv_set = {
    i_too_slow,
    i_left_clip,
    i_right_clip
  };

  sticky_flag_bank #(
    .WIDTH(CE_STICKY_W)
  ) u_conv_flags (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_set(conv_set),
    .i_clear(rd_conv),
    .o_flags(conv_sticky)
  );

  // muted indication is live, not sticky
  wire [DATA_W-1:0] conv_err_value = {
    4'h0, conv_sticky, i_converter_output_muted
  };

  // ***********************************************
  // converter mask register
  // ***********************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_mask <= CONV_MASK_RESET;
    end else if (wr_mask) begin
      conv_mask <= i_reg_wdata & CONV_MASK_USED;
    end
  end

  // ***********************************************
  // interrupt status register
  // ***********************************************
  wire [DATA_W-1:0] conv_enabled = conv_err_value & conv_mask;
  wire summary_set = |conv_enabled;

  wire [DATA_W-1:0] int_set = {
    summary_set,
    i_tx_status_buffer_loaded,
    i_tx_user_buffer_empty,
    i_tx_status_block_sent,
    i_rx_status_a_b_differ,
    i_rx_user_block_new,
    i_rx_status_block_event,
    i_rx_error_summary
  };

  sticky_flag_bank #(
    .WIDTH(DATA_W)
  ) u_int_flags (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_set(int_set),
    .i_clear(rd_int),
    .o_flags(int_flags)
  );

  // bit 3 is kept out of the interrupt by IRQ_CAPABLE
  wire [DATA_W-1:0] irq_sources = int_flags & i_interrupt_enables
    & IRQ_CAPABLE;
  assign o_irq = |irq_sources;

  // ***********************************************
  // read data
  // ***********************************************
  wire [DATA_W-1:0] read_mux =
    sel_conv ? conv_err_value :
    sel_mask ? conv_mask :
    sel_int ? int_flags : READ_IDLE;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= READ_IDLE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= read_mux;
      end
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  a_error_read_only: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_reg_wr && sel_conv && !i_reg_rd && conv_set == '0)
      |=> $stable(conv_sticky)
  ) else $error("write changed converter error flags");

  a_too_slow_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_too_slow |=> conv_sticky[CE_TOO_SLOW-1]
  ) else $error("too-slow flag not set");

  a_left_clip_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_left_clip ##1 !rd_conv [*3]) |=> conv_sticky[CE_LEFT_CLIP-1]
  ) else $error("left-clip flag lost before read");

  a_left_read_clear: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (rd_conv && !i_left_clip) |=> !conv_sticky[CE_LEFT_CLIP-1]
  ) else $error("left-clip flag not cleared by read");

  a_right_clip_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_right_clip ##1 !rd_conv [*3]) |=> conv_sticky[CE_RIGHT_CLIP-1]
  ) else $error("right-clip flag lost before read");

  a_right_read_clear: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (rd_conv && !i_right_clip) |=> !conv_sticky[CE_RIGHT_CLIP-1]
  ) else $error("right-clip flag not cleared by read");

  a_left_mask_path: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (conv_sticky[CE_LEFT_CLIP-1] && conv_mask[CE_LEFT_CLIP])
      |=> int_flags[IS_SUMMARY]
  ) else $error("enabled left clip did not reach summary");

  a_right_mask_path: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (conv_sticky[CE_RIGHT_CLIP-1] && conv_mask[CE_RIGHT_CLIP])
      |=> int_flags[IS_SUMMARY]
  ) else $error("enabled right clip did not reach summary");

  a_muted_mask_path: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_converter_output_muted && conv_mask[CE_MUTED])
      |=> int_flags[IS_SUMMARY]
  ) else $error("enabled muted indication did not reach summary");

  a_mask_blocks: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (conv_mask == '0 && !int_flags[IS_SUMMARY])
      |=> !int_flags[IS_SUMMARY]
  ) else $error("masked converter flags raised summary");

  a_tx_sent_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_tx_status_block_sent ##1 !rd_int [*2]) |=> int_flags[IS_TX_SENT]
  ) else $error("block-sent flag lost before read");

  a_differ_no_irq: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_irq |->
      |(int_flags & i_interrupt_enables & ~(8'h01 << IS_RX_DIFFER))
  ) else $error("status differ bit raised the interrupt");

  a_user_block_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_rx_user_block_new |=> int_flags[IS_RX_USER]
  ) else $error("user block flag not set");

  a_summary_latch: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (int_flags[IS_SUMMARY] && !rd_int) |=> int_flags[IS_SUMMARY]
  ) else $error("summary flag dropped without read");

  a_irq_follows: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (int_flags[IS_TX_SENT] && i_interrupt_enables[IS_TX_SENT]) |-> o_irq
  ) else $error("enabled status bit did not drive interrupt");

endmodule

// *** design/src_status_pkg.sv ***
// constants for the converter error and interrupt status block
// assumes a control-port deserializer that hands over byte register
// reads and writes as one-cycle strobes on i_clk
package src_status_pkg;

  // ***********************************************
  // register access
  // ***********************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONV_ERR = 7'h1A;
  localparam logic [ADDR_W-1:0] ADDR_CONV_MASK = 7'h1B;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 7'h1C;

  // ***********************************************
  // converter error fields
  // ***********************************************
  localparam int CE_TOO_SLOW = 3;
  localparam int CE_LEFT_CLIP = 2;
  localparam int CE_RIGHT_CLIP = 1;
  localparam int CE_MUTED = 0;
  localparam int CE_STICKY_W = 3;
  localparam logic [DATA_W-1:0] CONV_MASK_USED = 8'h07;
  localparam logic [DATA_W-1:0] CONV_MASK_RESET = 8'h00;

  // ***********************************************
  // interrupt status fields
  // ***********************************************
  localparam int IS_SUMMARY = 7;
  localparam int IS_TX_LOADED = 6;
  localparam int IS_TX_EMPTY = 5;
  localparam int IS_TX_SENT = 4;
  localparam int IS_RX_DIFFER = 3;
  localparam int IS_RX_USER = 2;
  localparam int IS_RX_STATUS = 1;
  localparam int IS_RX_ERROR = 0;
  localparam logic [DATA_W-1:0] IRQ_CAPABLE = 8'hF7;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

endpackage

// *** design/sticky_flag_bank.sv ***
// a bank of sticky flags, each set by hardware and cleared together
// assumes set and clear come from logic on the same clock
module sticky_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_flags
);
  import src_status_pkg::*;

  // ***********************************************
  // one flag per bit, set wins over clear
  // ***********************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_flags[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_flags[g] <= 1'b1;
        end else if (i_clear) begin
          o_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// *** testbench/tb.sv ***
// self-checking bench for the converter error and interrupt status block
// assumes byte register strobes and event inputs on one 125 MHz clock
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import src_status_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, muted = 0, rvalid, irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, en = '0, rdata;
  logic [3:1] cv = '0;
  logic [6:0] ev = '0;
  int n_fail = 0, checks = 0;
  always #4 clk = ~clk;
  src_error_and_interrupt_status dut (.i_clk(clk), .i_resetn(resetn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_too_slow(cv[3]),
    .i_left_clip(cv[2]), .i_right_clip(cv[1]),
    .i_converter_output_muted(muted), .i_tx_status_buffer_loaded(ev[6]),
    .i_tx_user_buffer_empty(ev[5]), .i_tx_status_block_sent(ev[4]),
    .i_rx_status_a_b_differ(ev[3]), .i_rx_user_block_new(ev[2]),
    .i_rx_status_block_event(ev[1]), .i_rx_error_summary(ev[0]),
    .i_interrupt_enables(en), .o_irq(irq));
  // ***********************************************
  // compare and bus tasks
  // ***********************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(negedge clk);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    tick();
    addr = a;
    wdata = d;
    wr = 1;
    tick();
    wr = 0;
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
    tick();
    addr = a;
    rd = 1;
    tick();
    rd = 0;
    chk1(rvalid, 1'b1);
    chk8(rdata, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_read_only();
    rd_reg(ADDR_CONV_MASK, 8'h00);
    cv = 3'b111;
    tick();
    cv = '0;
    wr_reg(ADDR_CONV_ERR, 8'h00);
    tick();
    rd_reg(ADDR_CONV_ERR, 8'h0e);
    rd_reg(ADDR_CONV_ERR, 8'h00);
    wr_reg(ADDR_CONV_MASK, 8'hff);
    rd_reg(ADDR_CONV_MASK, 8'h07);
    $display("test read_only done");
  endtask
  task automatic t_mask(input logic [7:0] m, input logic [3:1] c,
      input logic mu, input logic [7:0] e_err, input logic [7:0] e_st);
    wr_reg(ADDR_CONV_MASK, m);
    en = 8'h80;
    cv = c;
    muted = mu;
    tick();
    cv = '0;
    tick();
    tick();
    chk1(irq, e_st[7]);
    rd_reg(ADDR_CONV_ERR, e_err);
    muted = 0;
    tick();
    rd_reg(ADDR_INT_STATUS, e_st);
    rd_reg(ADDR_INT_STATUS, 8'h00);
    chk1(irq, 1'b0);
    $display("test mask %h done", m);
  endtask
  task automatic t_status();
    ev = 7'h1c;
    tick();
    ev = '0;
    en = 8'h08;
    tick();
    chk1(irq, 1'b0);
    en = 8'h10;
    tick();
    chk1(irq, 1'b1);
    rd_reg(ADDR_INT_STATUS, 8'h1c);
    rd_reg(ADDR_INT_STATUS, 8'h00);
    en = 8'hff;
    ev = 7'h7f;
    tick();
    ev = '0;
    tick();
    chk1(irq, 1'b1);
    rd_reg(ADDR_INT_STATUS, 8'h7f);
    chk1(irq, 1'b0);
    $display("test status done");
  endtask
  initial begin
    repeat (10) tick();
    resetn = 1;
    t_read_only();
    t_mask(8'h04, 3'b010, 1'b0, 8'h04, 8'h80);
    t_mask(8'h04, 3'b001, 1'b0, 8'h02, 8'h00);
    t_mask(8'h02, 3'b001, 1'b0, 8'h02, 8'h80);
    t_mask(8'h00, 3'b000, 1'b1, 8'h01, 8'h00);
    t_mask(8'h01, 3'b000, 1'b1, 8'h01, 8'h80);
    t_mask(8'h07, 3'b100, 1'b0, 8'h08, 8'h00);
    t_status();
    give_verdict();
  end
endmodule
